// [hw/usr_sig_mem.sv]
// usr_sig_mem: word store for the user-signature flash pages, one read and one write port.
// assumes a single clock; the read word comes out of a register one edge after rd_en_in.
`default_nettype none

module usr_sig_mem #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 9
) (
  input wire logic clk_in,
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in
);

  // ==========================================================================
  // elaboration checks
  generate
    if (DATA_W < 1 || ADDR_W < 2) begin : g_bad_size
      $error("usr_sig_mem: size not supported");
    end
  endgenerate

  // ==========================================================================
  // storage
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : usr_sig_mem

`default_nettype wire

// [hw/usr_sig_read.sv]
// usr_sig_read: test-port reader of the user-signature pages, single word and page stream.
// assumes an outer test-port controller supplying the instruction and Capture/Shift/Update
// pulses on test_clk_in, and on-chip programming logic filling the store on clk_in.
// What this block does
// - two address loads, read returns addressed word
// - stream leaves LSB first, may span pages
// - each stream Capture-DR with the read enable set loads the fetched word (zero if not ready), advances counter
// - first shifted data is valid, no dummy
`default_nettype none

package usr_pkg;
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_PROGRAM_COMMAND_MODE = 4'h5;
  localparam logic [IR_W-1:0] IR_PAGE_STREAM_LOAD = 4'h6;
  localparam logic [IR_W-1:0] IR_PAGE_STREAM_READ = 4'h7;
  localparam int DATA_W = 16;
  localparam int WORD_IDX_W = 7;
  localparam int PAGE_SEL_W = 2;
  localparam int ADDR_W = PAGE_SEL_W + WORD_IDX_W;
  localparam logic [7:0] OP_SIG_READ_EN = 8'h09;
  localparam logic [7:0] OP_LOAD_ADDR_HI = 8'h03;
  localparam logic [7:0] OP_LOAD_ADDR_LO = 8'h13;
  localparam logic [7:0] OP_READ_WORD = 8'h32;
  localparam logic [PAGE_SEL_W-1:0] PAGE_NONE = 2'h0;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [DATA_W-1:0] DR_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] arg;
  } usr_cmd_t;

  typedef struct packed {
    logic [PAGE_SEL_W-1:0] page;
    logic [WORD_IDX_W-1:0] word;
  } usr_addr_t;

  typedef enum logic [2:0] {
    CORE_IDLE = 3'b001,
    CORE_READ = 3'b010,
    CORE_DONE = 3'b100
  } usr_core_state_t;
endpackage : usr_pkg

module usr_sig_read import usr_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic test_clk_in,
  input wire logic test_reset_n_in,
  input wire logic [IR_W-1:0] ir_in,
  input wire logic capture_dr_in,
  input wire logic shift_dr_in,
  input wire logic update_dr_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic stream_ready_out,
  input wire logic prog_wr_en_in,
  input wire logic [ADDR_W-1:0] prog_wr_addr_in,
  input wire logic [DATA_W-1:0] prog_wr_data_in
);

  // ==========================================================================
  // test-clock side: data register, address counter, fetch requests
  logic [DATA_W-1:0] dr;
  usr_addr_t pc;
  usr_addr_t req_addr;
  usr_addr_t fetched_addr;
  logic [DATA_W-1:0] fetched_word;
  logic fetched_valid;
  logic req_toggle;
  logic req_pending;
  logic sig_read_en;
  logic read_armed;
  logic ack_meta;
  logic ack_sync;
  logic ack_seen;
  logic ack_toggle;
  logic [DATA_W-1:0] core_word;

  usr_cmd_t cmd;
  wire in_cmd_mode = (ir_in == IR_PROGRAM_COMMAND_MODE);
  wire in_stream = (ir_in == IR_PAGE_STREAM_READ);
  wire cmd_update = update_dr_in && in_cmd_mode;
  wire is_read_en = cmd_update && (cmd.opcode == OP_SIG_READ_EN);
  wire is_load_hi = cmd_update && sig_read_en && (cmd.opcode == OP_LOAD_ADDR_HI);
  wire is_load_lo = cmd_update && sig_read_en && (cmd.opcode == OP_LOAD_ADDR_LO);
  wire is_read = cmd_update && sig_read_en && (cmd.opcode == OP_READ_WORD);
  wire stream_capture = capture_dr_in && in_stream && sig_read_en;
  wire read_capture = capture_dr_in && in_cmd_mode && read_armed;
  wire ack_arrived = ack_sync != ack_seen;
  wire word_ready = fetched_valid && (fetched_addr == pc);
  // a fresh request only goes out once the last one is answered, so req_addr stays stable
  wire need_fetch = !req_pending && !word_ready;
  wire [ADDR_W-1:0] pc_plus = ADDR_W'(pc + 1'b1);

  assign cmd = usr_cmd_t'(dr);
  assign tdo_out = dr[0];

  always_ff @(posedge test_clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack_toggle;
      ack_sync <= ack_meta;
    end
  end

  always_ff @(posedge test_clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      dr <= DR_RESET;
    end else if (stream_capture || read_capture) begin
      dr <= word_ready ? fetched_word : DR_RESET;
    end else if (capture_dr_in) begin
      dr <= DR_RESET;
    end else if (shift_dr_in) begin
      dr <= {tdi_in, dr[DATA_W-1:1]};
    end
  end

  always_ff @(posedge test_clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      pc <= ADDR_RESET;
    end else if (is_load_hi) begin
      pc.page <= cmd.arg[PAGE_SEL_W-1:0];
    end else if (is_load_lo) begin
      pc.word <= cmd.arg[WORD_IDX_W-1:0];
    end else if (stream_capture) begin
      pc <= pc_plus;
    end
  end

  always_ff @(posedge test_clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      sig_read_en <= 1'b0;
      read_armed <= 1'b0;
    end else begin
      if (is_read_en) begin
        sig_read_en <= 1'b1;
      end else if (!in_cmd_mode && !in_stream) begin
        sig_read_en <= 1'b0;
      end
      if (is_read) begin
        read_armed <= 1'b1;
      end else if (read_capture || !in_cmd_mode) begin
        read_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge test_clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      req_toggle <= 1'b0;
      req_pending <= 1'b0;
      req_addr <= ADDR_RESET;
      ack_seen <= 1'b0;
      fetched_valid <= 1'b0;
      fetched_addr <= ADDR_RESET;
      fetched_word <= DR_RESET;
      stream_ready_out <= 1'b0;
    end else begin
      stream_ready_out <= word_ready;
      if (ack_arrived) begin
        ack_seen <= ack_sync;
        req_pending <= 1'b0;
        fetched_valid <= 1'b1;
        fetched_addr <= req_addr;
        fetched_word <= core_word;
      end else if (need_fetch) begin
        req_toggle <= !req_toggle;
        req_pending <= 1'b1;
        req_addr <= pc;
      end
    end
  end

  // ==========================================================================
  // core-clock side: answers each request toggle with one store read
  usr_core_state_t state;
  usr_core_state_t next_state;
  logic req_meta;
  logic req_sync;
  logic req_seen;
  logic [DATA_W-1:0] mem_word;

  wire req_arrived = req_sync != req_seen;
  wire mem_rd = (state == CORE_IDLE) && req_arrived;
  // addresses outside the three signature pages read as erased flash
  wire page_valid = req_addr.page != PAGE_NONE;

  always_comb begin
    next_state = state;
    case (state)
      CORE_IDLE: begin
        if (req_arrived) begin
          next_state = CORE_READ;
        end
      end
      CORE_READ: next_state = CORE_DONE;
      CORE_DONE: next_state = CORE_IDLE;
      default: next_state = CORE_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      req_meta <= req_toggle;
      req_sync <= req_meta;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= CORE_IDLE;
      req_seen <= 1'b0;
      ack_toggle <= 1'b0;
      core_word <= DR_RESET;
    end else begin
      state <= next_state;
      if (mem_rd) begin
        req_seen <= req_sync;
      end
      if (state == CORE_READ) begin
        core_word <= page_valid ? mem_word : ERASED_WORD;
      end
      if (state == CORE_DONE) begin
        ack_toggle <= !ack_toggle;
      end
    end
  end

  usr_sig_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clk_in(clk_in),
    .rd_en_in(mem_rd),
    .rd_addr_in(req_addr),
    .rd_data_out(mem_word),
    .wr_en_in(prog_wr_en_in),
    .wr_addr_in(prog_wr_addr_in),
    .wr_data_in(prog_wr_data_in)
  );

endmodule : usr_sig_read

`default_nettype wire

// [verification/usr_sig_read_chk.sv]
// checker: test-port output relations of the signature reader
// assumes a bind onto the reader's ports
`default_nettype none
module usr_chk import usr_pkg::*; (
  input wire logic test_clk_in,
  input wire logic test_reset_n_in,
  input wire logic [IR_W-1:0] ir_in,
  input wire logic capture_dr_in,
  input wire logic shift_dr_in,
  input wire logic tdi_in,
  input wire logic tdo_out,
  input wire logic stream_ready_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge test_clk_in); endclocking
  default disable iff (!test_reset_n_in);
  // ====
  // tdi history, so a 16-shift run can be tied to tdo
  logic [15:0] hist;
  logic [4:0] n;
  wire logic rd_mode = (ir_in == IR_PROGRAM_COMMAND_MODE) || (ir_in == IR_PAGE_STREAM_READ);
  always_ff @(posedge test_clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      n <= 5'h00;
      hist <= 16'h0000;
    end else if (capture_dr_in) begin
      n <= 5'h00;
    end else if (shift_dr_in) begin
      hist <= {tdi_in, hist[15:1]};
      n <= (n == 5'h10) ? n : n + 5'h01;
    end
  end
  property p_refuse; capture_dr_in && !rd_mode |=> !tdo_out; endproperty
  a_refuse: assert property (p_refuse) else $error("capture outside read modes");
  // ready is registered, so the level that ruled the capture shows one edge later
  property p_notrdy; capture_dr_in && rd_mode ##1 !stream_ready_out |-> !tdo_out; endproperty
  a_notrdy: assert property (p_notrdy) else $error("capture before fetch");
  property p_hold; !capture_dr_in && !shift_dr_in |=> $stable(tdo_out); endproperty
  a_hold: assert property (p_hold) else $error("tdo moved while idle");
  property p_lsb; n == 5'h10 |-> tdo_out == hist[0]; endproperty
  a_lsb: assert property (p_lsb) else $error("shift order wrong");
  property p_adv;
    capture_dr_in && ir_in == IR_PAGE_STREAM_READ && stream_ready_out |-> ##[1:3] !stream_ready_out;
  endproperty
  a_adv: assert property (p_adv) else $error("no refetch after capture");
endmodule : usr_chk
`default_nettype wire

// [verification/usr_host.sv]
// host model: test-port host; its clock runs only while it acts
// assumes tdo and ready from the reader, sampled with the clock low
`default_nettype none
module usr_host import usr_pkg::*; (
  output var logic tck_out = 1'b0,
  output var logic trst_n_out = 1'b0,
  output var logic [IR_W-1:0] ir_out = 4'h0,
  output var logic cap_out = 1'b0,
  output var logic sh_out = 1'b0,
  output var logic upd_out = 1'b0,
  output var logic tdi_out = 1'b0,
  input wire logic tdo_in,
  input wire logic rdy_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // inputs change with the clock low; idle tdi toggles so no stale level lingers
  task automatic cyc(input logic c, input logic s, input logic u, input logic d);
    cap_out = c;
    sh_out = s;
    upd_out = u;
    tdi_out = d;
    #80 tck_out = 1'b1;
    #80 tck_out = 1'b0;
  endtask : cyc
  task automatic idle;
    cyc(1'b0, 1'b0, 1'b0, ~tdi_out);
  endtask : idle
  task automatic rst;
    repeat (3) idle();
    trst_n_out = 1'b1;
    idle();
  endtask : rst
  task automatic ins(input logic [IR_W-1:0] v);
    ir_out = v;
    idle();
  endtask : ins
  task automatic cmd(input usr_cmd_t c);
    for (int i = 0; i < 16; i++) cyc(1'b0, 1'b1, 1'b0, c[i]);
    cyc(1'b0, 1'b0, 1'b1, ~tdi_out);
  endtask : cmd
  task automatic ld(input usr_addr_t a);
    cmd({OP_LOAD_ADDR_HI, 6'h00, a.page});
    cmd({OP_LOAD_ADDR_LO, 1'h0, a.word});
  endtask : ld
  task automatic wrdy;
    for (int n = 0; n < 32 && rdy_in !== 1'b1; n++) idle();
  endtask : wrdy
  task automatic rd(output logic [DATA_W-1:0] w);
    cyc(1'b1, 1'b0, 1'b0, ~tdi_out);
    for (int i = 0; i < DATA_W; i++) begin
      w[i] = tdo_in;
      cyc(1'b0, 1'b1, 1'b0, ~tdi_out);
    end
    idle();
  endtask : rd
endmodule : usr_host
`default_nettype wire

// [verification/usr_sig_read_tb_top.sv]
// bench top: fills the store on the core clock, then runs host scenarios
// assumes usr_host as the test-port host and usr_chk bound to the reader
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module usr_sig_read_tb_top import usr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr_en = 1'b0;
  logic [ADDR_W-1:0] wr_a = 9'h000;
  logic [DATA_W-1:0] wr_d = 16'h0000;
  logic [DATA_W-1:0] w;
  wire logic tck, trst_n, cap, sh, upd, tdi, tdo, rdy;
  wire logic [IR_W-1:0] ir;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 clk_in = ~clk_in;
  usr_sig_read dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .test_clk_in(tck),
    .test_reset_n_in(trst_n), .ir_in(ir), .capture_dr_in(cap), .shift_dr_in(sh),
    .update_dr_in(upd), .tdi_in(tdi), .tdo_out(tdo), .stream_ready_out(rdy),
    .prog_wr_en_in(wr_en), .prog_wr_addr_in(wr_a), .prog_wr_data_in(wr_d));
  usr_host host_u (.tck_out(tck), .trst_n_out(trst_n), .ir_out(ir), .cap_out(cap),
    .sh_out(sh), .upd_out(upd), .tdi_out(tdi), .tdo_in(tdo), .rdy_in(rdy));
  // ====
  function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {7'h55, a};
  endfunction : pat
  // settle time after a page erase, since the store has no completion flag to poll
  localparam int WR_WAIT = 8;
  task automatic er(input logic [PAGE_SEL_W-1:0] p);
    for (int i = 0; i < (1 << WORD_IDX_W); i++) begin
      @(negedge clk_in);
      wr_en = 1'b1;
      wr_a = {p, WORD_IDX_W'(i)};
      wr_d = ERASED_WORD;
    end
    @(negedge clk_in);
    wr_en = 1'b0;
    repeat (WR_WAIT) @(negedge clk_in);
  endtask : er
  task automatic wr(input logic [ADDR_W-1:0] a);
    @(negedge clk_in);
    wr_en = 1'b1;
    wr_a = a;
    wr_d = pat(a);
    @(negedge clk_in);
    wr_en = 1'b0;
  endtask : wr
  task automatic t_word;
    usr_addr_t a [3] = '{'{2'h2, 7'h00}, '{2'h3, 7'h7F}, '{2'h1, 7'h02}};
    host_u.ins(IR_PROGRAM_COMMAND_MODE);
    host_u.cmd({OP_SIG_READ_EN, 8'h00});
    foreach (a[i]) begin
      host_u.ld(a[i]);
      host_u.cmd({OP_READ_WORD, 8'h00});
      host_u.wrdy();
      host_u.rd(w);
      `CHK("word", pat(a[i]), w)
    end
    host_u.ld('{2'h3, 7'h00});
    host_u.cmd({OP_READ_WORD, 8'h00});
    host_u.wrdy();
    host_u.rd(w);
    `CHK("erased", ERASED_WORD, w)
    $display("t_word done");
  endtask : t_word
  task automatic t_ir;
    host_u.ld('{2'h3, 7'h10});
    host_u.rd(w);
    `CHK("unarmed", DR_RESET, w)
    host_u.ins(IR_PAGE_STREAM_LOAD);
    host_u.rd(w);
    `CHK("refused", DR_RESET, w)
    host_u.ins(IR_PROGRAM_COMMAND_MODE);
    host_u.cmd({OP_READ_WORD, 8'h00});
    host_u.wrdy();
    host_u.rd(w);
    `CHK("no enable", DR_RESET, w)
    $display("t_ir done");
  endtask : t_ir
  task automatic t_stream;
    host_u.ins(IR_PROGRAM_COMMAND_MODE);
    host_u.cmd({OP_SIG_READ_EN, 8'h00});
    host_u.ld('{2'h1, 7'h00});
    host_u.ins(IR_PAGE_STREAM_READ);
    for (int i = 0; i < 3; i++) begin
      host_u.wrdy();
      host_u.rd(w);
      `CHK("stream", pat({2'h1, 7'(i)}), w)
    end
    host_u.ins(IR_PROGRAM_COMMAND_MODE);
    host_u.ld('{2'h2, 7'h00});
    host_u.ins(IR_PAGE_STREAM_READ);
    host_u.wrdy();
    host_u.rd(w);
    `CHK("page2", pat(9'h100), w)
    $display("t_stream done");
  endtask : t_stream
  task automatic results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // ceiling well above the roughly 20000 cycles the scenarios need
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    #3 host_u.rst();
    for (int p = 1; p < 4; p++) er(PAGE_SEL_W'(p));
    wr(9'h080);
    wr(9'h081);
    wr(9'h082);
    wr(9'h100);
    wr(9'h1FF);
    t_word();
    t_ir();
    t_stream();
    results();
  end
endmodule : usr_sig_read_tb_top
bind usr_sig_read usr_chk chk_u (.test_clk_in(test_clk_in), .test_reset_n_in(test_reset_n_in),
  .ir_in(ir_in), .capture_dr_in(capture_dr_in), .shift_dr_in(shift_dr_in), .tdi_in(tdi_in),
  .tdo_out(tdo_out), .stream_ready_out(stream_ready_out));
`default_nettype wire
